// ---- hw/lr_latch.sv ----
// Set/reset latch with clear dominance and optional retention
`timescale 1ns/1ps
module lr_latch
  import lr_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic eval_en,
  input  wire logic preset,
  input  wire logic clear,
  input  wire logic retain_en,
  output logic      q
);

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  logic next_q;
  logic por_clear;

  assign next_q    = clear  ? Q_CLEAR :
                     preset ? Q_SET   : q;
  assign por_clear = !rstn && !retain_en;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Retained state simply ignores reset; the flop stands in for backed-up storage
  always_ff @(posedge ref_clk) begin
    if (por_clear) begin
      q <= Q_CLEAR;
    end else if (rstn && eval_en) begin
      q <= next_q;
    end
  end

endmodule

// ---- hw/lr_pkg.sv ----
// Shared constants and types for the latch and toggle relay blocks
package lr_pkg;

  // ----------------------------------------------------------------
  // Output levels
  // ----------------------------------------------------------------
  localparam logic Q_CLEAR = 1'h0;
  localparam logic Q_SET   = 1'h1;

  // ----------------------------------------------------------------
  // Evaluation cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned EVAL_PERIOD_NS = 160;
  localparam int unsigned EVAL_DIV       = (EVAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 8;
  localparam logic [DIV_W-1:0] DIV_ZERO  = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE   = 8'h01;

  // ----------------------------------------------------------------
  // Priority selection and toggle states
  // ----------------------------------------------------------------
  typedef enum logic {
    LR_CLEAR_WINS,
    LR_PRESET_DOMINANT
  } lr_prio_e;

  typedef enum logic {
    LR_OFF,
    LR_ON
  } lr_state_e;

endpackage

// ---- hw/lr_relay_top.sv ----
// Top of the binary memory blocks: latch, toggle relay and cycle divider
`timescale 1ns/1ps
module lr_relay_top
  import lr_pkg::*;
#(
  parameter int unsigned DIV     = EVAL_DIV,
  parameter bit          REDUCED = 1'b0
)(
  input  wire logic     ref_clk,
  input  wire logic     rstn,
  input  wire logic     latch_preset,
  input  wire logic     latch_clear,
  input  wire logic     latch_retain,
  input  wire logic     tog_trigger,
  input  wire logic     tog_preset,
  input  wire logic     tog_clear,
  input  wire lr_prio_e tog_prio,
  input  wire logic     tog_retain,
  output logic          latch_q,
  output logic          tog_q,
  output logic          eval_tick
);

  // ----------------------------------------------------------------
  // Evaluation cycle divider
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             div_wrap;

  assign div_wrap     = (div_cnt == DIV_ZERO);
  assign next_div_cnt = div_wrap ? DIV_LAST : (div_cnt - DIV_ONE);
  assign eval_tick    = rstn && div_wrap;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_cnt <= DIV_ZERO;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Function blocks
  // ----------------------------------------------------------------
  // Inputs are other program blocks on ref_clk, so no synchroniser
  lr_latch u_latch (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .eval_en   (eval_tick),
    .preset    (latch_preset),
    .clear     (latch_clear),
    .retain_en (latch_retain),
    .q         (latch_q)
  );

  lr_toggle #(
    .REDUCED (REDUCED)
  ) u_toggle (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .eval_en   (eval_tick),
    .trigger   (tog_trigger),
    .preset    (tog_preset),
    .clear     (tog_clear),
    .prio      (tog_prio),
    .retain_en (tog_retain),
    .q         (tog_q)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  logic chk_trig_prev;
  logic chk_rise;
  logic chk_pre;
  logic chk_tick_gap;
  logic [DIV_W-1:0] chk_gap;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chk_trig_prev <= 1'b0;
    end else if (eval_tick) begin
      chk_trig_prev <= tog_trigger;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || eval_tick) begin
      chk_gap <= DIV_ZERO;
    end else begin
      chk_gap <= chk_gap + DIV_ONE;
    end
  end

  assign chk_rise     = tog_trigger && !chk_trig_prev;
  assign chk_pre      = REDUCED ? 1'b0 : tog_preset;
  assign chk_tick_gap = (chk_gap <= DIV_LAST);

  // ----------------------------------------------------------------
  // Assertions: latch
  // ----------------------------------------------------------------
  property p_latch_hold;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && !latch_preset && !latch_clear)
      |=> $stable(latch_q);
  endproperty
  latch_hold_a: assert property (p_latch_hold)
    else $error("latch lost value with inputs low");

  property p_latch_set;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && latch_preset && !latch_clear)
      |=> latch_q == Q_SET;
  endproperty
  latch_set_a: assert property (p_latch_set)
    else $error("latch did not set");

  property p_latch_clear;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && latch_clear)
      |=> latch_q == Q_CLEAR;
  endproperty
  latch_clear_a: assert property (p_latch_clear)
    else $error("latch did not clear or clear lost priority");

  property p_latch_keep;
    @(posedge ref_clk)
      (!rstn && latch_retain)
      |=> latch_q == $past(latch_q);
  endproperty
  latch_keep_a: assert property (p_latch_keep)
    else $error("retained latch changed over reset");

  property p_latch_por;
    @(posedge ref_clk)
      (!rstn && !latch_retain)
      |=> latch_q == Q_CLEAR;
  endproperty
  latch_por_a: assert property (p_latch_por)
    else $error("non retained latch not cleared by reset");

  // ----------------------------------------------------------------
  // Assertions: toggle relay
  // ----------------------------------------------------------------
  property p_tog_flip;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && chk_rise && !tog_preset && !tog_clear)
      |=> tog_q != $past(tog_q);
  endproperty
  tog_flip_a: assert property (p_tog_flip)
    else $error("toggle did not invert on trigger rise");

  property p_tog_still;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && !chk_rise && !chk_pre && !tog_clear)
      |=> $stable(tog_q);
  endproperty
  tog_still_a: assert property (p_tog_still)
    else $error("toggle changed without trigger rise");

  property p_tog_ignore;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && !REDUCED && (tog_preset || tog_clear))
      |=> tog_q == $past(tog_preset && !(tog_clear && tog_prio == LR_CLEAR_WINS));
  endproperty
  tog_ignore_a: assert property (p_tog_ignore)
    else $error("trigger affected output while preset or clear high");

  property p_tog_set;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && !REDUCED && tog_preset && !tog_clear)
      |=> tog_q == Q_SET;
  endproperty
  tog_set_a: assert property (p_tog_set)
    else $error("preset pulse did not force output high");

  property p_tog_clr;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && tog_clear && !chk_pre)
      |=> tog_q == Q_CLEAR;
  endproperty
  tog_clr_a: assert property (p_tog_clr)
    else $error("clear pulse did not return output low");

  property p_prio_clear;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && tog_preset && tog_clear && tog_prio == LR_CLEAR_WINS)
      |=> tog_q == Q_CLEAR;
  endproperty
  prio_clear_a: assert property (p_prio_clear)
    else $error("clear lost priority in clear wins mode");

  property p_prio_preset;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && !REDUCED && tog_preset && tog_clear && tog_prio == LR_PRESET_DOMINANT)
      |=> tog_q == Q_SET;
  endproperty
  prio_preset_a: assert property (p_prio_preset)
    else $error("preset lost priority in preset dominant mode");

  property p_tog_keep;
    @(posedge ref_clk)
      (!rstn && tog_retain)
      |=> tog_q == $past(tog_q);
  endproperty
  tog_keep_a: assert property (p_tog_keep)
    else $error("retained toggle changed over reset");

  property p_tog_por;
    @(posedge ref_clk)
      (!rstn && !tog_retain)
      |=> tog_q == Q_CLEAR;
  endproperty
  tog_por_a: assert property (p_tog_por)
    else $error("non retained toggle not cleared by reset");

  property p_reduced_clr;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && REDUCED && tog_clear)
      |=> tog_q == Q_CLEAR;
  endproperty
  reduced_clr_a: assert property (p_reduced_clr)
    else $error("reduced variant clear ignored or preset acted");

  // ----------------------------------------------------------------
  // Assertions: evaluation cycle and reduced variant preset
  // ----------------------------------------------------------------
  property p_eval_only;
    @(posedge ref_clk) disable iff (!rstn)
      (!eval_tick)
      |=> ($stable(tog_q) && $stable(latch_q));
  endproperty
  eval_only_a: assert property (p_eval_only)
    else $error("output changed outside an evaluation cycle");

  property p_eval_gap;
    @(posedge ref_clk) disable iff (!rstn)
      chk_tick_gap;
  endproperty
  eval_gap_a: assert property (p_eval_gap)
    else $error("evaluation cycle spacing too long");

  property p_tick_restart;
    @(posedge ref_clk)
      (!rstn ##1 rstn)
      |-> eval_tick;
  endproperty
  tick_restart_a: assert property (p_tick_restart)
    else $error("no evaluation cycle right after reset release");

  property p_tick_single;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && DIV > 1)
      |=> !eval_tick;
  endproperty
  tick_single_a: assert property (p_tick_single)
    else $error("evaluation cycles back to back");

  property p_reduced_preset;
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && REDUCED && tog_preset && !tog_clear && !chk_rise)
      |=> $stable(tog_q);
  endproperty
  reduced_preset_a: assert property (p_reduced_preset)
    else $error("reduced variant reacted to preset");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cover_toggle_on: cover property (
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && chk_rise && !tog_q) ##1 tog_q
  );

  cover_toggle_off: cover property (
    @(posedge ref_clk) disable iff (!rstn)
      (eval_tick && chk_rise && tog_q) ##1 !tog_q
  );

  cover_prio_clash: cover property (
    @(posedge ref_clk) disable iff (!rstn)
      eval_tick && tog_preset && tog_clear
  );

  cover_latch_both: cover property (
    @(posedge ref_clk) disable iff (!rstn)
      eval_tick && latch_preset && latch_clear && latch_q
  );

  cover_retained: cover property (
    @(posedge ref_clk)
      (!rstn && tog_retain && tog_q) ##1 (rstn && tog_q)
  );

endmodule

// ---- hw/lr_toggle.sv ----
// Pulse toggle relay with selectable priority and optional retention
`timescale 1ns/1ps
module lr_toggle
  import lr_pkg::*;
#(
  parameter bit REDUCED = 1'b0
)(
  input  wire logic     ref_clk,
  input  wire logic     rstn,
  input  wire logic     eval_en,
  input  wire logic     trigger,
  input  wire logic     preset,
  input  wire logic     clear,
  input  wire lr_prio_e prio,
  input  wire logic     retain_en,
  output logic          q
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  lr_state_e state;
  lr_state_e next_state;
  logic      trig_prev;
  logic      rise;
  logic      preset_in;
  logic      eff_set;
  logic      eff_clr;
  logic      blocked;

  assign preset_in = REDUCED ? 1'b0 : preset;
  assign rise      = trigger && !trig_prev;
  assign blocked   = preset_in || clear;
  assign eff_clr   = (prio == LR_PRESET_DOMINANT && !REDUCED)
                     ? (clear && !preset_in) : clear;
  assign eff_set   = (prio == LR_CLEAR_WINS || REDUCED)
                     ? (preset_in && !clear) : preset_in;

  always_comb begin
    next_state = state;
    if (eff_clr) begin
      next_state = LR_OFF;
    end else if (eff_set) begin
      next_state = LR_ON;
    end else if (rise && !blocked) begin
      case (state)
        LR_OFF:  next_state = LR_ON;
        LR_ON:   next_state = LR_OFF;
        default: next_state = LR_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn && !retain_en) begin
      state <= LR_OFF;
    end else if (rstn && eval_en) begin
      state <= next_state;
    end
  end

  // Edge history restarts low, so a trigger held through reset counts once
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trig_prev <= 1'b0;
    end else if (eval_en) begin
      trig_prev <= trigger;
    end
  end

  assign q = (state == LR_ON) ? Q_SET : Q_CLEAR;

endmodule

// ---- tb/lr_relay_top_tb.sv ----
// Self-checking bench for the latch and toggle relay top
`timescale 1ns/1ps
`define CHK(name, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %s exp %0b got %0b", name, exp, got); end end
module lr_relay_top_tb;
  import lr_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] req;
    logic [2:0] exp;
  } lr_row_s;

  logic       ref_clk = 1'b0;
  logic       rstn    = 1'b0;
  logic [7:0] req     = 8'h00;
  logic       lp, lc, lr, tt, tp, tc, trn;
  lr_prio_e   pr;
  logic       latch_q, tog_q, tick, red_q;
  int         mismatches = 0;
  int         n_checks   = 0;
  int         cycles     = 0;

  // Inputs {lp,lc,lr,tt,tp,tc,prio,retain}, expected {latch, toggle, reduced}
  lr_row_s rows [17] = '{
    '{8'h00, 3'h0}, '{8'h80, 3'h4}, '{8'h00, 3'h4}, '{8'hC0, 3'h0},
    '{8'h10, 3'h3}, '{8'h00, 3'h3}, '{8'h10, 3'h0}, '{8'h00, 3'h0},
    '{8'h08, 3'h2}, '{8'h00, 3'h2}, '{8'h18, 3'h3}, '{8'h04, 3'h0},
    '{8'h0C, 3'h0}, '{8'h0E, 3'h2}, '{8'h06, 3'h0}, '{8'h10, 3'h3},
    '{8'h10, 3'h3}
  };

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  lr_upstream up (
    .ref_clk(ref_clk), .eval_tick(tick), .req(req), .latch_preset(lp), .latch_clear(lc),
    .latch_retain(lr), .tog_trigger(tt), .tog_preset(tp), .tog_clear(tc), .tog_prio(pr),
    .tog_retain(trn)
  );

  lr_relay_top #(.DIV(4), .REDUCED(1'b0)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .latch_preset(lp), .latch_clear(lc), .latch_retain(lr),
    .tog_trigger(tt), .tog_preset(tp), .tog_clear(tc), .tog_prio(pr), .tog_retain(trn),
    .latch_q(latch_q), .tog_q(tog_q), .eval_tick(tick)
  );

  // Reduced variant shares the stimulus; preset and priority must be ignored
  lr_relay_top #(.DIV(4), .REDUCED(1'b1)) uut_red (
    .ref_clk(ref_clk), .rstn(rstn), .latch_preset(lp), .latch_clear(lc), .latch_retain(lr),
    .tog_trigger(tt), .tog_preset(tp), .tog_clear(tc), .tog_prio(pr), .tog_retain(trn),
    .latch_q(), .tog_q(red_q), .eval_tick()
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_tick();
    logic t;
    do begin
      t = tick;
      @(posedge ref_clk);
    end while (t !== 1'b1);
    #1;
  endtask

  // One tick for the upstream to load, one for the relay to take it
  task automatic step(input logic [7:0] v);
    req = v;
    wait_tick();
    wait_tick();
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("eval_tick", 1'b0, tick)
    rstn = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check3(input logic [2:0] e);
    `CHK("latch_q", e[2], latch_q)
    `CHK("tog_q", e[1], tog_q)
    `CHK("red_q", e[0], red_q)
  endtask

  // Hang guard; a full run needs about 170 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    @(posedge ref_clk);
    #1;
    check3(3'h0);
    foreach (rows[i]) begin
      step(rows[i].req);
      check3(rows[i].exp);
    end
    // Retained set state must survive a reset pulse
    step(8'hA9);
    check3(3'h7);
    step(8'h21);
    do_reset();
    check3(3'h7);
    step(8'h00);
    check3(3'h7);
    do_reset();
    check3(3'h0);
    `CHK("eval_tick", 1'b0, tick)
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("eval_tick", 1'b1, tick)
    results();
  end
endmodule

// ---- tb/lr_upstream.sv ----
// Upstream function blocks feeding the relay inputs
`timescale 1ns/1ps
module lr_upstream
  import lr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       eval_tick,
  input  wire logic [7:0] req,
  output logic            latch_preset,
  output logic            latch_clear,
  output logic            latch_retain,
  output logic            tog_trigger,
  output logic            tog_preset,
  output logic            tog_clear,
  output lr_prio_e        tog_prio,
  output logic            tog_retain
);
  // ----------------------------------------------------------------
  // Held outputs
  // ----------------------------------------------------------------
  logic [7:0] drv = 8'h00;

  // Loads only at a tick, so every level spans the whole next tick
  always @(posedge ref_clk) begin
    if (eval_tick) begin
      drv <= #1 req;
    end
  end

  assign latch_preset = drv[7];
  assign latch_clear  = drv[6];
  assign latch_retain = drv[5];
  assign tog_trigger  = drv[4];
  assign tog_preset   = drv[3];
  assign tog_clear    = drv[2];
  assign tog_prio     = lr_prio_e'(drv[1]);
  assign tog_retain   = drv[0];
endmodule
